// File: pkg/fdh_cfg.svh
// register map, field positions and timing counts of the flash disk host front end
// assumes CLK_IN at FDH_CLK_MHZ; all times are converted to cycles here
`ifndef FDH_CFG_SVH
`define FDH_CFG_SVH

`define FDH_REG_CTRL 8'h00
`define FDH_REG_ADDR 8'h04
`define FDH_REG_CMD 8'h08
`define FDH_REG_WDATA 8'h0C
`define FDH_REG_RDATA 8'h10
`define FDH_REG_STATUS 8'h14

`define FDH_CTRL_MUX 0
`define FDH_CTRL_WIDE 1
`define FDH_CTRL_DEVRST 2
`define FDH_CTRL_RESET 3'h0

`define FDH_CMD_READ 0
`define FDH_CMD_LANE_LO 1
`define FDH_CMD_LANE_HI 2

`define FDH_STAT_BUSY 0
`define FDH_STAT_INITP 1
`define FDH_STAT_MUXON 2
`define FDH_STAT_IRQ 3
`define FDH_STAT_PEND 4

`define FDH_CLK_MHZ 10
`define FDH_T_ADDR_NS 100
`define FDH_T_LATCH_NS 100
`define FDH_T_SETUP_NS 100
`define FDH_T_STROBE_NS 300
`define FDH_T_HOLD_NS 100
`define FDH_T_RST_NS 2000
// least time rounded up to whole cycles, never below one
`define FDH_CYC(ns) ((((ns) * `FDH_CLK_MHZ + 999) / 1000) < 1 ? 1 : \
    (((ns) * `FDH_CLK_MHZ + 999) / 1000))

`endif

// File: pkg/fdh_pkg.sv
// types of the flash disk host front end
// assumes fdh_cfg.svh for the numeric constants
package fdh_pkg;
    typedef enum logic [6:0] {
        FDH_RESET  = 7'h01,
        FDH_IDLE   = 7'h02,
        FDH_ADDR   = 7'h04,
        FDH_LATCH  = 7'h08,
        FDH_SETUP  = 7'h10,
        FDH_STROBE = 7'h20,
        FDH_HOLD   = 7'h40
    } fdh_state_t;
endpackage

// File: hw/fdh_host.sv
// host controller driving the flash disk pins, ordered over an APB slave
// assumes the device straps its own identity and the bench resolves the data pins
`timescale 1ns/1ps
`default_nettype none
`include "fdh_cfg.svh"

// Operation
// [RQ1] device enters multiplexed mode on strobe fall
// [RQ2] host gives strobe fall before first read
// [RQ3] multiplexed: data pins carry address then data
// [RQ4] multiplexed: upper strap bit forced to zero
// [RQ5] device holds init pending while loading
// [RQ6] host waits for init pending negation
// [RQ7] byte mode uses only low lanes
// [RQ8] word when byte enable and A0 low
// [RQ9] odd byte on upper lanes
// [RQ10] even byte on lower lanes
// [RQ11] both high means no operation
// [RQ12] boot block answers 8 and 16 bit
// [RQ13] little endian byte ordering
// [RQ14] two straps give device number 0..3
// [RQ15] only selected identity answers register cycles
// [RQ16] multiplexed: low strap picks device 0/1
// [RQ17] interrupt control picks source and sensitivity
// [RQ18] software enables interrupt before long operation
// [RQ19] device timing from chip strobe edges
// [RQ20] standard mode: thirteen address lines
// [RQ21] multiplexed mode stays until power-on reset
module fdh_host
    import fdh_pkg::*;
#(
    parameter int ADDR_W = 13,
    parameter int DATA_W = 16,
    parameter int RST_CYC = `FDH_CYC(`FDH_T_RST_NS)
) (
    input wire logic CLK_IN,
    input wire logic RST_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    output logic CE_N_OUT,
    output logic OE_N_OUT,
    output logic WE_N_OUT,
    output logic ADDR_VALID_STROBE_N_OUT,
    output logic UPPER_BYTE_ENABLE_N_OUT,
    output logic WIDE_CFG_OUT,
    output logic POWER_ON_RESET_N_OUT,
    output logic [ADDR_W-1:0] ADDR_OUT,
    input wire logic [DATA_W-1:0] DATA_IN,
    output logic [DATA_W-1:0] DATA_OUT,
    output logic [1:0] DATA_OE_OUT,
    input wire logic INIT_PENDING_N_IN,
    input wire logic IRQ_N_IN
);
    localparam logic [7:0] CYC_ADDR = 8'(`FDH_CYC(`FDH_T_ADDR_NS) - 1);
    localparam logic [7:0] CYC_LATCH = 8'(`FDH_CYC(`FDH_T_LATCH_NS) - 1);
    localparam logic [7:0] CYC_SETUP = 8'(`FDH_CYC(`FDH_T_SETUP_NS) - 1);
    localparam logic [7:0] CYC_STROBE = 8'(`FDH_CYC(`FDH_T_STROBE_NS) - 1);
    localparam logic [7:0] CYC_HOLD = 8'(`FDH_CYC(`FDH_T_HOLD_NS) - 1);
    localparam logic [15:0] CYC_RST = 16'(RST_CYC - 1);

    fdh_state_t state_reg, state_next;
    logic [15:0] cnt_reg, cnt_next;
    logic [2:0] ctrl_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [2:0] cmd_reg;
    logic [DATA_W-1:0] wdata_reg, rdata_reg;
    logic pend_reg, mux_on_reg;
    logic [1:0] initp_sync_reg, irq_sync_reg;
    logic [DATA_W-1:0] data_s1_reg, data_s2_reg;
    logic [31:0] prdata_reg;
    logic setup_ph, wr_acc, mapped, cmd_wr, accept, cnt_zero;
    logic init_pending, is_read, lane_lo, lane_hi, a0, bhe_n;

    // [RQ18] irq level shown, pins synchronised
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            initp_sync_reg <= 2'h0;
            irq_sync_reg <= 2'h3;
            data_s1_reg <= '0;
            data_s2_reg <= '0;
        end else begin
            initp_sync_reg <= {initp_sync_reg[0], INIT_PENDING_N_IN};
            irq_sync_reg <= {irq_sync_reg[0], IRQ_N_IN};
            data_s1_reg <= DATA_IN;
            data_s2_reg <= data_s1_reg;
        end
    end
    assign init_pending = ~initp_sync_reg[1];

    // apb slave: zero wait states
    assign setup_ph = PSEL_IN & ~PENABLE_IN;
    assign wr_acc = PSEL_IN & PENABLE_IN & PWRITE_IN;
    always_comb begin
        case (PADDR_IN)
            `FDH_REG_CTRL, `FDH_REG_ADDR, `FDH_REG_CMD,
            `FDH_REG_WDATA, `FDH_REG_RDATA, `FDH_REG_STATUS: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end
    assign PREADY_OUT = 1'b1;
    assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~mapped;
    assign PRDATA_OUT = prdata_reg;
    assign cmd_wr = wr_acc & (PADDR_IN == `FDH_REG_CMD) & ~pend_reg
        & (state_reg == FDH_IDLE);

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            prdata_reg <= 32'h0;
        end else if (setup_ph) begin
            case (PADDR_IN)
                `FDH_REG_CTRL: prdata_reg <= {29'h0, ctrl_reg};
                `FDH_REG_ADDR: prdata_reg <= 32'(addr_reg);
                `FDH_REG_CMD: prdata_reg <= {29'h0, cmd_reg};
                `FDH_REG_WDATA: prdata_reg <= 32'(wdata_reg);
                `FDH_REG_RDATA: prdata_reg <= 32'(rdata_reg);
                `FDH_REG_STATUS: prdata_reg <= {27'h0, pend_reg, ~irq_sync_reg[1],
                    mux_on_reg, init_pending, state_reg != FDH_IDLE};
                default: prdata_reg <= 32'h0;
            endcase
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            ctrl_reg <= `FDH_CTRL_RESET;
            addr_reg <= '0;
            wdata_reg <= '0;
            cmd_reg <= 3'h0;
        end else begin
            if (wr_acc && PADDR_IN == `FDH_REG_CTRL) begin
                ctrl_reg <= PWDATA_IN[2:0];
            end else if (state_reg == FDH_RESET) begin
                ctrl_reg[`FDH_CTRL_DEVRST] <= 1'b0;
            end
            if (wr_acc && PADDR_IN == `FDH_REG_ADDR && state_reg == FDH_IDLE) begin
                addr_reg <= PWDATA_IN[ADDR_W-1:0];
            end
            if (wr_acc && PADDR_IN == `FDH_REG_WDATA && state_reg == FDH_IDLE) begin
                wdata_reg <= PWDATA_IN[DATA_W-1:0];
            end
            if (cmd_wr) begin
                cmd_reg <= PWDATA_IN[2:0];
            end
        end
    end

    // [RQ6] hold access until init done
    assign accept = pend_reg & ~init_pending & ~ctrl_reg[`FDH_CTRL_DEVRST];
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            pend_reg <= 1'b0;
        end else if (cmd_wr) begin
            pend_reg <= 1'b1;
        end else if (state_reg == FDH_IDLE && accept) begin
            pend_reg <= 1'b0;
        end
    end

    // [RQ21] mode held until device reset
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            mux_on_reg <= 1'b0;
        end else if (state_reg == FDH_RESET) begin
            mux_on_reg <= 1'b0;
        end else if (state_reg == FDH_ADDR) begin
            mux_on_reg <= 1'b1;
        end
    end

    assign cnt_zero = (cnt_reg == 16'h0);
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_zero ? 16'h0 : cnt_reg - 16'h1;
        case (state_reg)
            FDH_RESET: begin
                if (cnt_zero) begin
                    state_next = FDH_IDLE;
                end
            end
            FDH_IDLE: begin
                if (ctrl_reg[`FDH_CTRL_DEVRST]) begin
                    state_next = FDH_RESET;
                    cnt_next = CYC_RST;
                end else if (accept && ctrl_reg[`FDH_CTRL_MUX]) begin
                    // [RQ2] strobe falls before chip enable
                    state_next = FDH_ADDR;
                    cnt_next = 16'(CYC_ADDR);
                end else if (accept) begin
                    state_next = FDH_SETUP;
                    cnt_next = 16'(CYC_SETUP);
                end
            end
            FDH_ADDR: begin
                if (cnt_zero) begin
                    state_next = FDH_LATCH;
                    cnt_next = 16'(CYC_LATCH);
                end
            end
            FDH_LATCH: begin
                if (cnt_zero) begin
                    state_next = FDH_SETUP;
                    cnt_next = 16'(CYC_SETUP);
                end
            end
            FDH_SETUP: begin
                if (cnt_zero) begin
                    state_next = FDH_STROBE;
                    cnt_next = 16'(CYC_STROBE);
                end
            end
            FDH_STROBE: begin
                if (cnt_zero) begin
                    state_next = FDH_HOLD;
                    cnt_next = 16'(CYC_HOLD);
                end
            end
            FDH_HOLD: begin
                if (cnt_zero) begin
                    state_next = FDH_IDLE;
                end
            end
            default: begin
                state_next = FDH_IDLE;
                cnt_next = 16'h0;
            end
        endcase
    end

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            state_reg <= FDH_RESET;
            cnt_reg <= CYC_RST;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
        end
    end

    // lane selection from command and width
    assign is_read = cmd_reg[`FDH_CMD_READ];
    // [RQ7] byte mode low lanes, mux mode all
    assign lane_lo = ~ctrl_reg[`FDH_CTRL_WIDE] | ctrl_reg[`FDH_CTRL_MUX] | cmd_reg[`FDH_CMD_LANE_LO];
    assign lane_hi = ctrl_reg[`FDH_CTRL_MUX] | (ctrl_reg[`FDH_CTRL_WIDE] & cmd_reg[`FDH_CMD_LANE_HI]);
    // [RQ8] [RQ9] [RQ10] [RQ11] byte enable and A0 encoding
    assign a0 = ctrl_reg[`FDH_CTRL_WIDE] ? ~lane_lo : addr_reg[0];
    assign bhe_n = ~lane_hi;

    // read capture at strobe end, active lanes only
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            rdata_reg <= '0;
        end else if (state_reg == FDH_STROBE && cnt_zero && is_read) begin
            // [RQ13] low lanes hold least significant byte
            rdata_reg <= data_s2_reg & {{8{lane_hi}}, {8{lane_lo}}};
        end
    end

    // pin drive, all from flops
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            CE_N_OUT <= 1'b1;
            OE_N_OUT <= 1'b1;
            WE_N_OUT <= 1'b1;
            ADDR_VALID_STROBE_N_OUT <= 1'b1;
            UPPER_BYTE_ENABLE_N_OUT <= 1'b1;
            WIDE_CFG_OUT <= 1'b0;
            POWER_ON_RESET_N_OUT <= 1'b0;
            ADDR_OUT <= '0;
            DATA_OUT <= '0;
            DATA_OE_OUT <= 2'h0;
        end else begin
            CE_N_OUT <= ~(state_next == FDH_SETUP || state_next == FDH_STROBE
                || state_next == FDH_HOLD);
            OE_N_OUT <= ~(state_next == FDH_STROBE && is_read);
            WE_N_OUT <= ~(state_next == FDH_STROBE && !is_read);
            ADDR_VALID_STROBE_N_OUT <= ~(state_next == FDH_ADDR);
            UPPER_BYTE_ENABLE_N_OUT <= ctrl_reg[`FDH_CTRL_MUX] ? 1'b1 : bhe_n;
            WIDE_CFG_OUT <= ctrl_reg[`FDH_CTRL_WIDE] | ctrl_reg[`FDH_CTRL_MUX];
            POWER_ON_RESET_N_OUT <= (state_next != FDH_RESET);
            // [RQ20] thirteen address lines in standard mode
            ADDR_OUT <= ctrl_reg[`FDH_CTRL_MUX] ? '0 : {addr_reg[ADDR_W-1:1], a0};
            if (state_next == FDH_ADDR || state_next == FDH_LATCH) begin
                // [RQ3] address phase on the data pins
                DATA_OUT <= DATA_W'(addr_reg);
                DATA_OE_OUT <= 2'h3;
            end else if (!is_read && (state_next == FDH_SETUP
                || state_next == FDH_STROBE || state_next == FDH_HOLD)) begin
                DATA_OUT <= wdata_reg;
                DATA_OE_OUT <= {lane_hi, lane_lo};
            end else begin
                DATA_OUT <= '0;
                DATA_OE_OUT <= 2'h0;
            end
        end
    end
endmodule
`default_nettype wire

// File: testbench/fdh_host_properties.sv
// pin and bus assertions of the flash disk host front end
// assumes binding into fdh_host, one clock, synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module fdh_host_properties #(
    parameter int ADDR_W = 13
) (
    input wire logic CLK_IN,
    input wire logic RST_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PSLVERR_OUT,
    input wire logic CE_N_OUT,
    input wire logic OE_N_OUT,
    input wire logic WE_N_OUT,
    input wire logic ADDR_VALID_STROBE_N_OUT,
    input wire logic UPPER_BYTE_ENABLE_N_OUT,
    input wire logic WIDE_CFG_OUT,
    input wire logic POWER_ON_RESET_N_OUT,
    input wire logic [ADDR_W-1:0] ADDR_OUT,
    input wire logic [1:0] DATA_OE_OUT,
    input wire logic INIT_PENDING_N_IN
);
    logic mux_reg;
    // remembers that the address strobe was used since the last device reset
    always_ff @(posedge CLK_IN) begin
        if (RST_IN || !POWER_ON_RESET_N_OUT) begin
            mux_reg <= 1'b0;
        end else if (!ADDR_VALID_STROBE_N_OUT) begin
            mux_reg <= 1'b1;
        end
    end
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);
    sequence strobe3(s);
        !s [*3] ##1 s;
    endsequence
    chk_init_wait: assert property ((!INIT_PENDING_N_IN) [*5] |-> CE_N_OUT)
        else $error("device selected while init pending");
    chk_avd_order: assert property ($fell(ADDR_VALID_STROBE_N_OUT)
        |-> OE_N_OUT && POWER_ON_RESET_N_OUT)
        else $error("address strobe outside allowed window");
    chk_avd_addr: assert property ($fell(ADDR_VALID_STROBE_N_OUT)
        |-> DATA_OE_OUT == 2'b11 ##1 ADDR_VALID_STROBE_N_OUT)
        else $error("address phase not on both data lanes");
    chk_mux_addr0: assert property (mux_reg && !CE_N_OUT
        |-> ADDR_OUT == '0 && UPPER_BYTE_ENABLE_N_OUT)
        else $error("address lines active in multiplexed mode");
    chk_mux_lanes: assert property (mux_reg && !WE_N_OUT
        |-> DATA_OE_OUT == 2'b11)
        else $error("multiplexed write not on both lanes");
    chk_byte_lane: assert property (!WIDE_CFG_OUT && !WE_N_OUT
        |-> DATA_OE_OUT == 2'b01 && UPPER_BYTE_ENABLE_N_OUT)
        else $error("byte mode drives upper lane");
    chk_wide_lane: assert property (
        WIDE_CFG_OUT && !mux_reg && !WE_N_OUT
        |-> DATA_OE_OUT == {!UPPER_BYTE_ENABLE_N_OUT, !ADDR_OUT[0]})
        else $error("driven lanes disagree with lane code");
    chk_read_float: assert property (!OE_N_OUT
        |-> DATA_OE_OUT == 2'b00 && WE_N_OUT)
        else $error("host drives data during read");
    chk_read_pulse: assert property ($fell(OE_N_OUT)
        |-> strobe3(OE_N_OUT) and !CE_N_OUT [*4])
        else $error("read strobe not one clean pulse inside select");
    chk_write_pulse: assert property ($fell(WE_N_OUT)
        |-> strobe3(WE_N_OUT) and !CE_N_OUT [*4])
        else $error("write strobe not one clean pulse inside select");
    chk_ce_first: assert property ($fell(CE_N_OUT) |-> OE_N_OUT && WE_N_OUT)
        else $error("strobe low when select falls");
    chk_err_phase: assert property (PSLVERR_OUT |-> PSEL_IN && PENABLE_IN)
        else $error("error response outside access phase");
endmodule
bind fdh_host fdh_host_properties #(.ADDR_W(ADDR_W)) u_fdh_host_properties (.*);
`default_nettype wire

// File: testbench/fdh_dev_model.sv
// behavioural flash disk device: pin-timed word memory with lane steering
// assumes the bench resolves the shared data pins from both enables
`timescale 1ns/1ps
`default_nettype none
module fdh_dev_model #(
    parameter int INIT_NS = 6000,
    // strapped identity, lone device
    parameter logic [1:0] ID_STRAP = 2'h0,
    // device select register location, an arbitrary free word
    parameter logic [12:0] SEL_ADDR = 13'h1FFE
) (
    input wire logic ce_n_in,
    input wire logic oe_n_in,
    input wire logic we_n_in,
    input wire logic avd_n_in,
    input wire logic bhe_n_in,
    input wire logic wide_in,
    input wire logic por_n_in,
    input wire logic [12:0] addr_in,
    input wire logic [15:0] data_in,
    output logic [15:0] data_out,
    output logic [1:0] data_oe_out,
    output logic init_pending_n_out
);
    logic [15:0] mem [0:15];
    logic mux_reg = 1'b0;
    logic [12:0] mux_addr_reg = 13'h0000;
    logic [1:0] sel_reg = 2'h0;
    wire [12:0] a = mux_reg ? mux_addr_reg : addr_in;
    wire [15:0] w = mem[a[4:1]];
    wire [1:0] dev_id = mux_reg ? {1'b0, ID_STRAP[0]} : ID_STRAP;
    wire sel_ok = (sel_reg == dev_id);
    wire sel_wr = (a == SEL_ADDR);
    wire [1:0] ln = mux_reg ? 2'b11 : (!wide_in ? 2'b01 : {~bhe_n_in, ~a[0]});
    assign data_out = (wide_in || mux_reg) ? w : {8'h00, a[0] ? w[15:8] : w[7:0]};
    assign data_oe_out = (!ce_n_in && !oe_n_in && sel_ok) ? ln : 2'b00;
    always @(por_n_in) begin
        init_pending_n_out = 1'b0;
        if (por_n_in) begin
            #(INIT_NS);
            init_pending_n_out = 1'b1;
        end
    end
    always @(negedge avd_n_in or negedge por_n_in) begin
        mux_reg = por_n_in;
    end
    always @(posedge avd_n_in) begin
        mux_addr_reg = data_in[12:0];
    end
    always @(posedge we_n_in or negedge por_n_in) begin
        if (!por_n_in) begin
            sel_reg = 2'h0;
        end else if (!ce_n_in && sel_wr) begin
            sel_reg = data_in[1:0];
        end else if (!ce_n_in && sel_ok && !wide_in && !mux_reg) begin
            if (a[0]) begin
                mem[a[4:1]][15:8] = data_in[7:0];
            end else begin
                mem[a[4:1]][7:0] = data_in[7:0];
            end
        end else if (!ce_n_in && sel_ok) begin
            if (ln[0]) begin
                mem[a[4:1]][7:0] = data_in[7:0];
            end
            if (ln[1]) begin
                mem[a[4:1]][15:8] = data_in[15:8];
            end
        end
    end
endmodule
`default_nettype wire

// File: testbench/testbench.sv
// self-checking bench: apb orders drive the host front end against a device model
// assumes a 10 MHz clock and a shortened device reset count
`timescale 1ns/1ps
`default_nettype none
`include "fdh_cfg.svh"
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd_data;
    logic pready, pslverr, ce_n, oe_n, we_n, avd_n, bhe_n, wide, por_n, init_n, rd_err;
    logic [12:0] addr;
    logic [15:0] hdata, ddata, dq;
    logic [15:0] idle_pat = 16'hA5A5;
    logic [1:0] hoe, doe;
    int error_cnt = 0;
    int checks_done = 0;
    always #50 clk = ~clk;
    always @(posedge clk) idle_pat <= ~idle_pat;
    // released lanes show a pattern that changes every cycle
    assign dq[7:0] = hoe[0] ? hdata[7:0] : (doe[0] ? ddata[7:0] : idle_pat[7:0]);
    assign dq[15:8] = hoe[1] ? hdata[15:8] : (doe[1] ? ddata[15:8] : idle_pat[15:8]);
    fdh_host #(.RST_CYC(2)) u_fdh_host (.CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel),
        .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
        .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .CE_N_OUT(ce_n),
        .OE_N_OUT(oe_n), .WE_N_OUT(we_n), .ADDR_VALID_STROBE_N_OUT(avd_n),
        .UPPER_BYTE_ENABLE_N_OUT(bhe_n), .WIDE_CFG_OUT(wide), .POWER_ON_RESET_N_OUT(por_n),
        .ADDR_OUT(addr), .DATA_IN(dq), .DATA_OUT(hdata), .DATA_OE_OUT(hoe),
        .INIT_PENDING_N_IN(init_n), .IRQ_N_IN(1'b1));
    fdh_dev_model u_fdh_dev_model (.ce_n_in(ce_n), .oe_n_in(oe_n), .we_n_in(we_n),
        .avd_n_in(avd_n), .bhe_n_in(bhe_n), .wide_in(wide), .por_n_in(por_n),
        .addr_in(addr), .data_in(dq), .data_out(ddata), .data_oe_out(doe),
        .init_pending_n_out(init_n));
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic fail(input string m);
        error_cnt++;
        $display("mismatch at %0t: %s", $time, m);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            fail("apb answer timeout");
            tally_and_finish();
        end
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string m);
        apb(1'b0, a, 32'h0);
        checks_done++;
        if (rd_data !== exp) fail(m);
    endtask
    task automatic wait_idle();
        int n;
        for (n = 0; n < 100; n++) begin
            apb(1'b0, `FDH_REG_STATUS, 32'h0);
            if (rd_data[`FDH_STAT_BUSY] === 1'b0 && rd_data[`FDH_STAT_PEND] === 1'b0) break;
        end
        if (n == 100) begin
            fail("command never completed");
            tally_and_finish();
        end
    endtask
    task automatic issue(input logic [12:0] a, input logic [2:0] cmd, input logic [15:0] wd);
        apb(1'b1, `FDH_REG_ADDR, {19'h0, a});
        apb(1'b1, `FDH_REG_WDATA, {16'h0, wd});
        apb(1'b1, `FDH_REG_CMD, {29'h0, cmd});
    endtask
    task automatic op(input logic [12:0] a, input logic [2:0] cmd, input logic [15:0] wd,
        input logic [15:0] exp);
        issue(a, cmd, wd);
        wait_idle();
        if (cmd[0]) rd_chk(`FDH_REG_RDATA, {16'h0, exp}, "device read data");
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        for (int n = 0; n < 50 && por_n !== 1'b1; n++) @(posedge clk);
        if (por_n !== 1'b1) begin
            fail("device reset never released");
            tally_and_finish();
        end
        rd_chk(`FDH_REG_STATUS, 32'h2, "init pending not shown");
        rd_chk(`FDH_REG_CTRL, {29'h0, `FDH_CTRL_RESET}, "control reset value");
        rd_chk(8'h18, 32'h0, "unmapped read data");
        checks_done++;
        if (rd_err !== 1'b1) fail("unmapped access without error");
        apb(1'b1, `FDH_REG_CTRL, 32'h2);
        issue(13'h0002, 3'b110, 16'h1234);
        rd_chk(`FDH_REG_STATUS, 32'h12, "command not held back");
        wait_idle();
        op(13'h0002, 3'b100, 16'hABCD, 16'h0);
        op(13'h0002, 3'b000, 16'hFFFF, 16'h0);
        op(13'h0002, 3'b111, 16'h0, 16'hAB34);
        op(13'h0002, 3'b011, 16'h0, 16'h0034);
        op(13'h0002, 3'b101, 16'h0, 16'hAB00);
        op(13'h0002, 3'b001, 16'h0, 16'h0000);
        apb(1'b1, `FDH_REG_CTRL, 32'h0);
        op(13'h0003, 3'b010, 16'h005A, 16'h0);
        op(13'h0003, 3'b011, 16'h0, 16'h005A);
        apb(1'b1, `FDH_REG_CTRL, 32'h2);
        op(13'h0002, 3'b111, 16'h0, 16'h5A34);
        apb(1'b1, `FDH_REG_CTRL, 32'h1);
        op(13'h0004, 3'b110, 16'hC0DE, 16'h0);
        op(13'h0004, 3'b111, 16'h0, 16'hC0DE);
        rd_chk(`FDH_REG_STATUS, 32'h4, "multiplexed mode not shown");
        apb(1'b1, `FDH_REG_CTRL, 32'h4);
        wait_idle();
        rd_chk(`FDH_REG_STATUS, 32'h2, "device reset kept mux mode");
        apb(1'b1, `FDH_REG_CTRL, 32'h2);
        op(13'h0002, 3'b111, 16'h0, 16'h5A34);
        op(13'h1FFE, 3'b110, 16'h0001, 16'h0);
        op(13'h0002, 3'b110, 16'hFFFF, 16'h0);
        op(13'h1FFE, 3'b110, 16'h0000, 16'h0);
        op(13'h0002, 3'b111, 16'h0, 16'h5A34);
        tally_and_finish();
    end
endmodule
`default_nettype wire
